// *** gpt_pkg.sv ***
// Package for the three general purpose timers: register map, fields, resets.
// Assumes an APB slave with 32-bit data, one register per aligned word.
package gpt_pkg;

  // Register byte offsets
  localparam logic [7:0] GPT_OFS_CON1  = 8'h00;
  localparam logic [7:0] GPT_OFS_CNT1  = 8'h04;
  localparam logic [7:0] GPT_OFS_PER1  = 8'h08;
  localparam logic [7:0] GPT_OFS_CON2  = 8'h0c;
  localparam logic [7:0] GPT_OFS_CNT2  = 8'h10;
  localparam logic [7:0] GPT_OFS_PER2  = 8'h14;
  localparam logic [7:0] GPT_OFS_CON3  = 8'h18;
  localparam logic [7:0] GPT_OFS_CNT3  = 8'h1c;
  localparam logic [7:0] GPT_OFS_PER3  = 8'h20;
  localparam logic [7:0] GPT_OFS_FLAGS = 8'h24;
  localparam logic [7:0] GPT_OFS_IDLE  = 8'h28;

  // Control word field positions
  localparam int GPT_BIT_RUN   = 15;
  localparam int GPT_BIT_SIDL  = 13;
  localparam int GPT_BIT_GATE  = 6;
  localparam int GPT_BIT_PS_HI = 5;
  localparam int GPT_BIT_PS_LO = 4;
  localparam int GPT_BIT_T32   = 3;
  localparam int GPT_BIT_SYNC  = 2;
  localparam int GPT_BIT_CS    = 1;

  // Writable bit masks per control word
  localparam logic [15:0] GPT_MASK_CON1 = 16'ha076;
  localparam logic [15:0] GPT_MASK_CON2 = 16'ha07a;
  localparam logic [15:0] GPT_MASK_CON3 = 16'ha072;

  // Reset values
  localparam logic [15:0] GPT_RST_CON = 16'h0000;
  localparam logic [15:0] GPT_RST_CNT = 16'h0000;
  localparam logic [15:0] GPT_RST_PER = 16'hffff;

  // Prescale terminal counts for codes 00, 01, 10, 11
  localparam logic [7:0] GPT_PS_DIV1   = 8'h00;
  localparam logic [7:0] GPT_PS_DIV8   = 8'h07;
  localparam logic [7:0] GPT_PS_DIV64  = 8'h3f;
  localparam logic [7:0] GPT_PS_DIV256 = 8'hff;

endpackage

// *** gpt_prescale.sv ***
// Prescaler: passes every 1st, 8th, 64th or 256th input tick.
// Assumes tick_in is a one-cycle pulse in the pclk domain.
`timescale 1ns/1ps
module gpt_prescale
  import gpt_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       clear,
  input  wire logic [1:0] sel,
  input  wire logic       tick_in,
  output logic            tick_out
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  wire  [7:0] term = (sel == 2'b00) ? GPT_PS_DIV1 :
                     (sel == 2'b01) ? GPT_PS_DIV8 :
                     (sel == 2'b10) ? GPT_PS_DIV64 : GPT_PS_DIV256;
  wire        hit  = tick_in && (cnt_q >= term);

  assign cnt_d    = clear ? 8'h00 : (hit ? 8'h00 : (tick_in ? cnt_q + 8'h01 : cnt_q));
  assign tick_out = hit;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cnt_q <= 8'h00;
    else
      cnt_q <= cnt_d;
  end
endmodule

// *** gpt_edge_sync.sv ***
// Two-flop synchroniser with rising-edge pulse output.
// Assumes pin_in is asynchronous to pclk.
`timescale 1ns/1ps
module gpt_edge_sync (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_in,
  output logic      level,
  output logic      rise
);
  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign level = s2_q;
  assign rise  = s2_q && !s3_q;
endmodule

// *** gpt_timers.sv ***
// Three 16-bit timers with APB register access; timers 2 and 3 pair to 32 bits.
// Assumes pins are asynchronous, idle_mode comes from pclk logic.
`timescale 1ns/1ps
// Contract
// - Timer1 counts pclk internally, pin externally
// - Timer1 source bit1, sync bit2, gate bit6
// - Run bit 15 starts and stops counting
// - Stop-in-idle bit 13 halts in Idle
// - Gate enable only honoured on internal clock
// - Prescale bits 5-4 divide 1/8/64/256
// - Timer1 sync bit picks sync or async
// - Timer1 synchronises after its prescaler
// - Timer1 external mode counts pin rising edges
// - Timer1 can run from 32 kHz clock
// - Timer2 synchronises external clock after prescaler
// - Timer3 synchronises external clock before prescaler
// - Timers 2/3 have no asynchronous counter mode
// - Timers 2/3 internal clock is Fosc/2
// - Timer2 bit 3 joins pair into 32 bits
// - Timer3 holds high word, timer2 low
// - Pair governed by timer2 control bits, except timer3 idle-bit
// - Pair interrupts through timer3 flag
// - Pair runs in Idle only if timer3 idle-bit clear
// - Unimplemented control bits read zero
module gpt_timers
  import gpt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        idle_mode,
  input  wire logic        first_timer_ext_clock_pin,
  input  wire logic        timer2_ext_clock_pin,
  input  wire logic        timer3_ext_clock_pin,
  output logic             irq1,
  output logic             irq2,
  output logic             irq3
);
  // Registers
  logic [15:0] con1_q;
  logic [15:0] con2_q;
  logic [15:0] con3_q;
  logic [15:0] cnt1_q;
  logic [15:0] cnt2_q;
  logic [15:0] cnt3_q;
  logic [15:0] per1_q;
  logic [15:0] per2_q;
  logic [15:0] per3_q;
  logic [2:0]  flag_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;

  // Bus decode
  wire setup   = psel && !penable;
  wire wr      = psel && penable && pwrite && pready_q;
  wire rd_sel  = psel && !pwrite;
  wire hit_c1  = paddr == GPT_OFS_CON1;
  wire hit_n1  = paddr == GPT_OFS_CNT1;
  wire hit_p1  = paddr == GPT_OFS_PER1;
  wire hit_c2  = paddr == GPT_OFS_CON2;
  wire hit_n2  = paddr == GPT_OFS_CNT2;
  wire hit_p2  = paddr == GPT_OFS_PER2;
  wire hit_c3  = paddr == GPT_OFS_CON3;
  wire hit_n3  = paddr == GPT_OFS_CNT3;
  wire hit_p3  = paddr == GPT_OFS_PER3;
  wire hit_fl  = paddr == GPT_OFS_FLAGS;
  wire hit_id  = paddr == GPT_OFS_IDLE;
  wire mapped  = hit_c1 | hit_n1 | hit_p1 | hit_c2 | hit_n2 | hit_p2 |
                 hit_c3 | hit_n3 | hit_p3 | hit_fl | hit_id;
  wire [15:0] wd = pwdata[15:0];

  // Control fields
  wire pair   = con2_q[GPT_BIT_T32];
  wire run1   = con1_q[GPT_BIT_RUN];
  wire run2   = con2_q[GPT_BIT_RUN];
  wire run3   = con3_q[GPT_BIT_RUN] && !pair;
  wire cs1    = con1_q[GPT_BIT_CS];
  wire cs2    = con2_q[GPT_BIT_CS];
  wire cs3    = con3_q[GPT_BIT_CS];
  wire gate1  = con1_q[GPT_BIT_GATE] && !cs1;
  wire gate2  = con2_q[GPT_BIT_GATE] && !cs2;
  wire gate3  = con3_q[GPT_BIT_GATE] && !cs3;
  wire sync1  = con1_q[GPT_BIT_SYNC] && cs1;
  // Idle halts per timer; the pair obeys timer3's idle bit
  wire halt1  = idle_mode && con1_q[GPT_BIT_SIDL];
  wire halt2  = idle_mode && (pair ? con3_q[GPT_BIT_SIDL]
                                   : con2_q[GPT_BIT_SIDL]);
  wire halt3  = idle_mode && con3_q[GPT_BIT_SIDL];

  // Pin synchronisers
  wire p1_lvl;
  wire p1_rise;
  wire p2_lvl;
  wire p2_rise;
  wire p3_lvl;
  wire p3_rise;
  gpt_edge_sync u_sync1
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (first_timer_ext_clock_pin),
    .level   (p1_lvl),
    .rise    (p1_rise)
  );
  gpt_edge_sync u_sync2
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (timer2_ext_clock_pin),
    .level   (p2_lvl),
    .rise    (p2_rise)
  );
  gpt_edge_sync u_sync3
  (
    .pclk    (pclk),
    .presetn (presetn),
    .pin_in  (timer3_ext_clock_pin),
    .level   (p3_lvl),
    .rise    (p3_rise)
  );

  // Input ticks: pclk (instruction clock) or gated pclk, or pin edges
  // The pin may be a 32 kHz crystal clock on timer1
  // Timer1 async mode still counts pin edges; sampled here as the device has one clock
  wire in1 = cs1 ? p1_rise
                 : (gate1 ? p1_lvl : 1'b1);
  wire in2 = cs2 ? p2_rise : (gate2 ? p2_lvl : 1'b1);
  wire in3 = cs3 ? p3_rise : (gate3 ? p3_lvl : 1'b1);

  // Prescalers; pair uses timer2's prescale
  wire tk1;
  wire tk2;
  wire tk3;
  gpt_prescale u_ps1
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (!run1),
    .sel      (con1_q[GPT_BIT_PS_HI:GPT_BIT_PS_LO]),
    .tick_in  (in1 && !halt1),
    .tick_out (tk1)
  );
  gpt_prescale u_ps2
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (!run2),
    .sel      (con2_q[GPT_BIT_PS_HI:GPT_BIT_PS_LO]),
    .tick_in  (in2 && !halt2),
    .tick_out (tk2)
  );
  gpt_prescale u_ps3
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .clear    (!run3),
    .sel      (con3_q[GPT_BIT_PS_HI:GPT_BIT_PS_LO]),
    .tick_in  (in3 && !halt3),
    .tick_out (tk3)
  );

  // Prescaled pin ticks resynchronised: timer1 in sync mode, timer2 in external mode
  logic tk1_q;
  logic tk2_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tk1_q <= 1'b0;
      tk2_q <= 1'b0;
    end
    else
    begin
      tk1_q <= tk1 && run1;
      tk2_q <= tk2 && run2;
    end
  end
  wire cnt_tk1 = sync1 ? tk1_q : tk1;
  wire cnt_tk2 = cs2 ? tk2_q : tk2;

  // Count advance
  wire adv1 = run1 && cnt_tk1 && !halt1;
  wire adv2 = run2 && cnt_tk2 && !halt2;
  wire adv3 = run3 && tk3 && !halt3;

  // Period match
  wire        m1    = cnt1_q == per1_q;
  wire        m2    = cnt2_q == per2_q;
  wire        m3    = cnt3_q == per3_q;
  wire [31:0] cnt32 = {cnt3_q, cnt2_q};
  wire [31:0] per32 = {per3_q, per2_q};
  wire        m32   = cnt32 == per32;
  wire [31:0] nxt32 = m32 ? 32'h0000_0000 : cnt32 + 32'h0000_0001;

  wire ev1 = adv1 && m1;
  wire ev2 = !pair && adv2 && m2;
  wire ev3 = pair ? (adv2 && m32) : (adv3 && m3);

  // Next values
  logic [15:0] cnt1_d;
  logic [15:0] cnt2_d;
  logic [15:0] cnt3_d;
  assign cnt1_d = (wr && hit_n1) ? wd :
                  adv1 ? (m1 ? 16'h0000 : cnt1_q + 16'h0001) : cnt1_q;
  assign cnt2_d = (wr && hit_n2) ? wd :
                  (pair && adv2) ? nxt32[15:0] :
                  adv2 ? (m2 ? 16'h0000 : cnt2_q + 16'h0001) : cnt2_q;
  assign cnt3_d = (wr && hit_n3) ? wd :
                  (pair && adv2) ? nxt32[31:16] :
                  adv3 ? (m3 ? 16'h0000 : cnt3_q + 16'h0001) : cnt3_q;

  // Flags: hardware set wins over software write-one-to-clear
  wire [2:0] ev     = {ev3, ev2, ev1};
  wire [2:0] fl_clr = (wr && hit_fl) ? pwdata[2:0] : 3'b000;
  wire [2:0] flag_d = ev | (flag_q & ~fl_clr);

  // Read mux; control words read as stored, so unimplemented bits read zero
  wire [15:0] rd16 = hit_c1 ? con1_q :
                     hit_n1 ? cnt1_q :
                     hit_p1 ? per1_q :
                     hit_c2 ? con2_q :
                     hit_n2 ? cnt2_q :
                     hit_p2 ? per2_q :
                     hit_c3 ? con3_q :
                     hit_n3 ? cnt3_q :
                     hit_p3 ? per3_q :
                     hit_fl ? {13'h0000, flag_q} :
                     hit_id ? {15'h0000, idle_mode} : 16'h0000;

  // Control registers; unimplemented bits are never stored
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      con1_q <= GPT_RST_CON;
    else if (wr && hit_c1)
      con1_q <= wd & GPT_MASK_CON1;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      con2_q <= GPT_RST_CON;
    else if (wr && hit_c2)
      con2_q <= wd & GPT_MASK_CON2;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      con3_q <= GPT_RST_CON;
    else if (wr && hit_c3)
      con3_q <= wd & GPT_MASK_CON3;
  end

  // Periods
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      per1_q <= GPT_RST_PER;
    else if (wr && hit_p1)
      per1_q <= wd;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      per2_q <= GPT_RST_PER;
    else if (wr && hit_p2)
      per2_q <= wd;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      per3_q <= GPT_RST_PER;
    else if (wr && hit_p3)
      per3_q <= wd;
  end

  // Counters
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt1_q <= GPT_RST_CNT;
      cnt2_q <= GPT_RST_CNT;
      cnt3_q <= GPT_RST_CNT;
    end
    else
    begin
      cnt1_q <= cnt1_d;
      cnt2_q <= cnt2_d;
      cnt3_q <= cnt3_d;
    end
  end

  // Period flags
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flag_q <= 3'b000;
    else
      flag_q <= flag_d;
  end

  // First access cycle, the one wait state before ready
  wire acc_first = psel && penable && !pready_q;

  // APB answer: one wait state, ready in the second access cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end
    else
    begin
      pready_q  <= acc_first;
      pslverr_q <= acc_first && !mapped;
      prdata_q  <= (acc_first && rd_sel) ? {16'h0000, rd16} : 32'h0000_0000;
    end
  end

  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign prdata  = prdata_q;
  assign irq1    = flag_q[0];
  assign irq2    = flag_q[1];
  assign irq3    = flag_q[2];

  // Setup phase is decoded only for clarity of the access phase
  wire unused_setup = setup;
endmodule

// *** gpt_pin_model.sv ***
// Far-side model of the three external clock and gate pins.
// Assumes pclk is the device clock; pins idle low and move after its edges.
`timescale 1ns/1ps
module gpt_pin_model (
  input  wire logic pclk,
  output logic      pin1,
  output logic      pin2,
  output logic      pin3
);
  logic [2:0] lv = 3'h0;
  assign pin1 = lv[0];
  assign pin2 = lv[1];
  assign pin3 = lv[2];
  // Rising edges on one pin, three cycles high and three low each
  task pulse(input int i, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      lv[i] <= 1'b1;
      repeat (3) @(posedge pclk);
      lv[i] <= 1'b0;
      repeat (2) @(posedge pclk);
    end
  endtask
  // One high level of n cycles, as a gate
  task hold(input int i, input int n);
    @(posedge pclk);
    lv[i] <= 1'b1;
    repeat (n) @(posedge pclk);
    lv[i] <= 1'b0;
  endtask
endmodule

// *** gpt_timers_sva.sv ***
// Checker for the timer block's APB answers and period flags.
// Assumes it is bound to gpt_timers.
`timescale 1ns/1ps
module gpt_timers_sva
  import gpt_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic        irq1,
  input  wire logic        irq2,
  input  wire logic        irq3
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire        rdq = pready && !pwrite;
  wire        fw  = pready && pwrite && paddr == GPT_OFS_FLAGS;
  wire [15:0] cm  = paddr == GPT_OFS_CON1 ? GPT_MASK_CON1 :
                    paddr == GPT_OFS_CON2 ? GPT_MASK_CON2 :
                    paddr == GPT_OFS_CON3 ? GPT_MASK_CON3 : 16'hffff;
  a_wait_state: assert property ($rose(penable) && psel |-> !pready ##1 pready)
    else $error("ready not in second access cycle");
  a_ready_qual: assert property (pready |-> psel && penable)
    else $error("ready without access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_map: assert property (pready |->
    pslverr == !(paddr[1:0] == 2'b00 && paddr <= GPT_OFS_IDLE))
    else $error("error flag wrong for address");
  a_upper_zero: assert property (rdq |-> prdata[31:16] == 16'h0)
    else $error("upper read bits set");
  a_ctl_unimpl: assert property (rdq |-> (prdata[15:0] & ~cm) == 16'h0)
    else $error("unimplemented control bit set");
  a_flag1_hold: assert property (irq1 && !(fw && pwdata[0]) |=> irq1)
    else $error("flag 1 dropped");
  a_flag2_hold: assert property (irq2 && !(fw && pwdata[1]) |=> irq2)
    else $error("flag 2 dropped");
  a_flag3_hold: assert property (irq3 && !(fw && pwdata[2]) |=> irq3)
    else $error("flag 3 dropped");
endmodule

// *** gpt_timers_test.sv ***
// Testbench for the timer block: APB master, pin model, scenarios.
// Assumes gpt_pkg, gpt_timers, gpt_pin_model and the checker are compiled.
`timescale 1ns/1ps
module gpt_timers_test;
  import gpt_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, idle_mode;
  logic        p1, p2, p3, irq1, irq2, irq3, err;
  logic [7:0]  paddr, b;
  logic [31:0] pwdata, prdata, q, s;
  int          n_mismatch = 0;
  int          num_checks = 0;
  int          dv [4] = '{1, 8, 64, 256};
  logic [15:0] m [3] = '{GPT_MASK_CON1, GPT_MASK_CON2, GPT_MASK_CON3};
  gpt_timers i_gpt_timers (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .idle_mode, .first_timer_ext_clock_pin(p1),
    .timer2_ext_clock_pin(p2), .timer3_ext_clock_pin(p3), .irq1, .irq2, .irq3);
  gpt_pin_model i_gpt_pin_model (.pclk, .pin1(p1), .pin2(p2), .pin3(p3));
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("wrong value at %0t: %h expected %h", $time, seen, exp);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
    chk(k < 50, 1);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task t_regs;
    rd(GPT_OFS_PER2); chk(q, 32'hffff); chk(err, 0);
    rd(8'h3c); chk(err, 1); chk(q, 0);
    for (int t = 0; t < 3; t++)
    begin
      b = 8'(t * 12);
      rd(b); chk(q, 0);
      wr(b, 32'hffffffff); rd(b); chk(q, {16'h0, m[t]});
      wr(b, 0);
    end
  endtask
  task t_prescale;
    for (int t = 0; t < 3; t++)
      for (int c = 0; c < 4; c++)
      begin
        b = 8'(t * 12);
        wr(b + 8'h4, 0); wr(b, 32'h8000 | (c << 4)); wt(dv[c] * 16);
        wr(b, 0); rd(b + 8'h4); chk(q >= 16 && q <= 22, 1);
        s = q; wt(20); rd(b + 8'h4); chk(q, s);
      end
  endtask
  task t_ext;
    for (int k = 0; k < 4; k++)
    begin
      b = 8'((k > 0 ? k - 1 : 0) * 12);
      wr(b + 8'h4, 0); wr(b, k == 0 ? 32'h8042 : 32'h8046);
      i_gpt_pin_model.pulse(k > 0 ? k - 1 : 0, 5); wt(6);
      wr(b, 0); rd(b + 8'h4); chk(q, 5);
    end
  endtask
  task t_gate;
    wr(GPT_OFS_CNT1, 0); wr(GPT_OFS_CON1, 32'h8040);
    i_gpt_pin_model.hold(0, 30); wt(10);
    wr(GPT_OFS_CON1, 0); rd(GPT_OFS_CNT1); chk(q >= 28 && q <= 34, 1);
  endtask
  task t_idle;
    idle_mode <= 1'b1;
    wr(GPT_OFS_CNT1, 0); wr(GPT_OFS_CON1, 32'ha000); wt(20);
    wr(GPT_OFS_CON1, 0); rd(GPT_OFS_CNT1); chk(q, 0);
    wr(GPT_OFS_CON1, 32'h8000); wt(20);
    wr(GPT_OFS_CON1, 0); rd(GPT_OFS_CNT1); chk(q >= 20 && q <= 30, 1);
    wr(GPT_OFS_CNT2, 0); wr(GPT_OFS_CON3, 32'h2000); wr(GPT_OFS_CON2, 32'h8008); wt(20);
    wr(GPT_OFS_CON2, 32'h8); rd(GPT_OFS_CNT2); chk(q, 0);
    wr(GPT_OFS_CON3, 0); wr(GPT_OFS_CON2, 32'h8008); wt(20);
    wr(GPT_OFS_CON2, 32'h8); rd(GPT_OFS_CNT2); chk(q >= 20 && q <= 30, 1);
    wr(GPT_OFS_CON3, 0); wr(GPT_OFS_CON2, 0);
    idle_mode <= 1'b0;
  endtask
  task t_pair;
    wr(GPT_OFS_FLAGS, 7); wr(GPT_OFS_CNT2, 32'hfffe); wr(GPT_OFS_CNT3, 2);
    wr(GPT_OFS_PER2, 32'hffff); wr(GPT_OFS_PER3, 2); wr(GPT_OFS_CON3, 32'h0030);
    wr(GPT_OFS_CON2, 32'h8008); wt(20);
    chk(irq3, 1);
    chk(irq2, 0);
    wr(GPT_OFS_CON2, 32'h8); rd(GPT_OFS_CNT3); chk(q, 0);
    rd(GPT_OFS_CNT2); chk(q >= 20 && q <= 28, 1);
    wr(GPT_OFS_CON2, 0); wr(GPT_OFS_FLAGS, 4); chk(irq3, 0);
    wr(GPT_OFS_PER1, 4); wr(GPT_OFS_CNT1, 0); wr(GPT_OFS_CON1, 32'h8000); wt(12);
    wr(GPT_OFS_CON1, 0); chk(irq1, 1);
    rd(GPT_OFS_CNT1); chk(q <= 4, 1);
    wr(GPT_OFS_FLAGS, 1); chk(irq1, 0);
  endtask
  initial
  begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  initial
  begin
    presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h0; pwdata = 32'h0; idle_mode = 1'b0;
    wt(10);
    presetn <= 1'b1;
    wt(1);
    t_regs; t_prescale; t_ext; t_gate; t_idle; t_pair;
    finish_test;
  end
  initial
  begin
    wt(40000);
    n_mismatch++;
    finish_test;
  end
endmodule
bind gpt_timers gpt_timers_sva i_gpt_timers_sva (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq1, .irq2, .irq3);
